// file: dv/tb_uart_fifo_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ua_defines.svh"

module tb_uart_fifo_interrupt_control;
    import ua_pkg::*;
    logic clk;
    logic rst;
    ua_req_t req;
    logic [7:0] rdData;
    logic irq;
    logic txSlotAvail_n;
    logic rxDataAvail_n;
    ua_rxchar_t rxChar;
    logic baudTick16;
    logic modemChange;
    logic txValid;
    logic [7:0] txData;
    logic txReady;
    logic txShiftBusy;
    ua_fmt_t fmt;
    logic stall;
    int failures;
    int checks;
    logic [7:0] rv;

    ua_fifo_irq_ctrl dut_u (.clk(clk), .rst(rst), .req(req), .rdData(rdData), .irq(irq),
        .txSlotAvail_n(txSlotAvail_n), .rxDataAvail_n(rxDataAvail_n), .rxChar(rxChar),
        .baudTick16(baudTick16), .modemChange(modemChange), .txValid(txValid),
        .txData(txData), .txReady(txReady), .txShiftBusy(txShiftBusy), .fmt(fmt));

    ua_tx_sink sink_u (.clk(clk), .rst(rst), .txValid(txValid), .txData(txData),
        .txReady(txReady), .txShiftBusy(txShiftBusy), .stall(stall));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one register access; read data lands on the take edge and is sampled one edge later
    task automatic acc(input logic isRd, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{cs: 1'b1, rd: isRd, wr: !isRd, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        #1;
        rv = rdData;
    endtask

    task automatic rxIn(input logic [7:0] d, input logic fe);
        @(posedge clk);
        rxChar <= '{valid: 1'b1, data: d, parityErr: 1'b0, framingErr: fe, breakErr: 1'b0};
        @(posedge clk);
        rxChar <= '0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic waitGot(input int n);
        int i;
        i = 0;
        while (sink_u.nGot != n && i < 500)
        begin
            @(posedge clk);
            i++;
        end
        if (sink_u.nGot != n)
        begin
            failures++;
            $display("ERROR %0t sink byte count stuck", $time);
            summarize();
        end
    endtask

    task automatic t_reset();
        settle();
        chk(irq, 1'b0, "irq");
        chk(txSlotAvail_n, 1'b0, "tx pin");
        chk(rxDataAvail_n, 1'b1, "rx pin");
        acc(1, `UA_OFF_IER, 8'h00);
        chk(rv, 8'h00, "enable");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'h01, "status");
        acc(1, `UA_OFF_LSR, 8'h00);
        chk(rv, 8'h60, "line status");
    endtask

    task automatic t_format();
        ua_stop_t stp;
        for (int i = 0; i < 8; i++)
        begin
            acc(0, `UA_OFF_LCR, 8'(i));
            acc(1, `UA_OFF_LCR, 8'h00);
            chk(rv, 8'(i), "line control");
            stp = !i[2] ? UA_STOP_ONE : (i[1:0] == 2'h0 ? UA_STOP_ONE_HALF : UA_STOP_TWO);
            chk({1'b0, fmt}, {1'b0, 4'(5 + i % 4), stp}, "format");
        end
    endtask

    task automatic t_ier();
        acc(0, `UA_OFF_IER, 8'hFF);
        acc(1, `UA_OFF_IER, 8'h00);
        chk(rv, 8'h0F, "enable");
        acc(0, `UA_OFF_IER, 8'h00);
    endtask

    // control bits without the enable bit must not take
    task automatic t_mode1rx();
        acc(0, `UA_OFF_FCR_ISR, 8'h08);
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'h01, "status");
        acc(0, `UA_OFF_FCR_ISR, 8'h4F);
        for (int k = 0; k < 3; k++)
            rxIn(8'(k), 1'b0);
        settle();
        chk(rxDataAvail_n, 1'b1, "rx pin");
        rxIn(8'h03, 1'b0);
        settle();
        chk(rxDataAvail_n, 1'b0, "rx pin");
        for (int k = 0; k < 3; k++)
            acc(1, `UA_OFF_DATA, 8'h00);
        settle();
        chk(rxDataAvail_n, 1'b0, "rx pin");
        acc(1, `UA_OFF_DATA, 8'h00);
        settle();
        chk(rxDataAvail_n, 1'b1, "rx pin");
    endtask

    task automatic t_trig();
        int lv [4] = '{1, 4, 8, 14};
        acc(0, `UA_OFF_IER, 8'h01);
        for (int t = 0; t < 4; t++)
        begin
            acc(0, `UA_OFF_FCR_ISR, {2'(t), 6'h03});
            for (int k = 0; k < lv[t] - 1; k++)
                rxIn(8'(16 * t + k), 1'b0);
            settle();
            chk(irq, 1'b0, "irq below level");
            rxIn(8'hEE, 1'b0);
            settle();
            chk(irq, 1'b1, "irq at level");
            acc(1, `UA_OFF_FCR_ISR, 8'h00);
            chk(rv, 8'hC4, "status");
            acc(1, `UA_OFF_DATA, 8'h00);
            chk(rv, lv[t] > 1 ? 8'(16 * t) : 8'hEE, "rx data");
            settle();
            chk(irq, 1'b0, "irq dropped");
            chk(rxDataAvail_n, lv[t] > 1 ? 1'b0 : 1'b1, "rx pin");
            acc(0, `UA_OFF_FCR_ISR, {2'(t), 6'h03});
            settle();
            chk(rxDataAvail_n, 1'b1, "rx pin after clear");
            acc(1, `UA_OFF_LSR, 8'h00);
            chk(rv & 8'h01, 8'h00, "data ready");
        end
    endtask

    // stalled sink fills the two-entry buffer, then the holder or fifo
    task automatic t_tx();
        @(posedge clk);
        stall <= 1'b1;
        acc(0, `UA_OFF_FCR_ISR, 8'h00);
        acc(0, `UA_OFF_DATA, 8'hA0);
        chk(txSlotAvail_n, 1'b0, "tx pin drained to buffer");
        for (int i = 1; i < 4; i++)
            acc(0, `UA_OFF_DATA, 8'(8'hA0 + i));
        settle();
        chk(txSlotAvail_n, 1'b1, "tx pin full");
        @(posedge clk);
        stall <= 1'b0;
        waitGot(3);
        repeat (8) @(posedge clk);
        #1;
        for (int i = 0; i < 3; i++)
            chk(sink_u.seen[i], 8'(8'hA0 + i), "tx byte");
        chk(txSlotAvail_n, 1'b0, "tx pin empty");
        acc(1, `UA_OFF_LSR, 8'h00);
        chk(rv, 8'h60, "line status");
        @(posedge clk);
        stall <= 1'b1;
        acc(0, `UA_OFF_FCR_ISR, 8'h09);
        acc(0, `UA_OFF_IER, 8'h02);
        for (int i = 0; i < 17; i++)
            acc(0, `UA_OFF_DATA, 8'(8'hB0 + i));
        settle();
        chk(txSlotAvail_n, 1'b0, "tx pin one free");
        acc(0, `UA_OFF_DATA, 8'hC1);
        settle();
        chk(txSlotAvail_n, 1'b1, "tx pin full");
        acc(0, `UA_OFF_DATA, 8'hFF);
        @(posedge clk);
        stall <= 1'b0;
        waitGot(21);
        repeat (8) @(posedge clk);
        #1;
        for (int i = 0; i < 17; i++)
            chk(sink_u.seen[3 + i], 8'(8'hB0 + i), "tx byte");
        chk(sink_u.seen[20], 8'hC1, "tx last byte");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC2, "status");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC1, "status");
    endtask

    task automatic t_prio();
        acc(0, `UA_OFF_FCR_ISR, 8'h07);
        acc(0, `UA_OFF_IER, 8'h00);
        acc(0, `UA_OFF_IER, 8'h0F);
        @(posedge clk);
        modemChange <= 1'b1;
        @(posedge clk);
        modemChange <= 1'b0;
        rxIn(8'h5A, 1'b1);
        settle();
        chk(irq, 1'b1, "irq");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC6, "status");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC4, "status");
        acc(1, `UA_OFF_DATA, 8'h00);
        chk(rv, 8'h5A, "rx data");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC2, "status");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC0, "status");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hC1, "status");
        settle();
        chk(irq, 1'b0, "irq");
    endtask

    // idle fifo below trigger raises the timeout source
    task automatic t_timeout();
        acc(0, `UA_OFF_FCR_ISR, 8'h4B);
        rxIn(8'h77, 1'b0);
        settle();
        chk(irq, 1'b0, "irq before timeout");
        @(posedge clk);
        baudTick16 <= 1'b1;
        repeat (720) @(posedge clk);
        baudTick16 <= 1'b0;
        settle();
        chk(irq, 1'b1, "irq on timeout");
        chk(rxDataAvail_n, 1'b0, "rx pin on timeout");
        acc(1, `UA_OFF_FCR_ISR, 8'h00);
        chk(rv, 8'hCC, "status");
        acc(1, `UA_OFF_DATA, 8'h00);
        chk(rv, 8'h77, "rx data");
        settle();
        chk(rxDataAvail_n, 1'b1, "rx pin empty");
    endtask

    initial
    begin
        rst = 1'b1;
        req = '0;
        rxChar = '0;
        baudTick16 = 1'b0;
        modemChange = 1'b0;
        stall = 1'b0;
        failures = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_format();
        t_ier();
        t_mode1rx();
        t_trig();
        t_tx();
        t_prio();
        t_timeout();
        summarize();
    end
endmodule // tb_uart_fifo_interrupt_control

`default_nettype wire

// file: dv/ua_tx_sink.sv
`timescale 1ns/1ps
`default_nettype none

// stands in for the tx shift register; stall holds it off to fill the buffer
module ua_tx_sink #(
    parameter int SHIFT = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // byte stream from the block
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    output logic txShiftBusy,
    // bench control
    input wire logic stall
);
    logic [7:0] seen [0:31];
    int nGot;
    int shiftLeft;

    // busy for a few cycles per byte, so ready drops like a real shifter
    assign txReady = !stall && shiftLeft == 0;
    assign txShiftBusy = shiftLeft != 0;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nGot <= 0;
            shiftLeft <= 0;
        end
        else if (txValid && txReady)
        begin
            seen[nGot[4:0]] <= txData;
            nGot <= nGot + 1;
            shiftLeft <= SHIFT;
        end
        else if (shiftLeft != 0)
        begin
            shiftLeft <= shiftLeft - 1;
        end
    end
endmodule // ua_tx_sink

`default_nettype wire

// file: pkg/ua_defines.svh
`ifndef UA_DEFINES_SVH
`define UA_DEFINES_SVH

// register offsets on the 3-bit address
`define UA_OFF_DATA 3'h0
`define UA_OFF_IER 3'h1
`define UA_OFF_FCR_ISR 3'h2
`define UA_OFF_LCR 3'h3
`define UA_OFF_LSR 3'h5

// fifo control field positions
`define UA_FCR_EN 0
`define UA_FCR_RXCLR 1
`define UA_FCR_TXCLR 2
`define UA_FCR_MODE 3

// reset values
`define UA_IER_RST 4'h0
`define UA_LCR_RST 8'h00
`define UA_TRIG_RST 2'h0

// interrupt identification codes, bits 3:0
`define UA_ID_LS 4'h6
`define UA_ID_RDA 4'h4
`define UA_ID_TO 4'hC
`define UA_ID_THRE 4'h2
`define UA_ID_MS 4'h0
`define UA_ID_NONE 4'h1

// sizes and timing counts
`define UA_DEPTH 5'h10
`define UA_TICKS_PER_BIT 16
`define UA_TO_CHARS 4

`endif

// file: pkg/ua_pkg.sv
package ua_pkg;

    typedef enum logic [2:0] {
        UA_STOP_ONE = 3'b001,
        UA_STOP_ONE_HALF = 3'b010,
        UA_STOP_TWO = 3'b100
    } ua_stop_t;

    typedef struct packed {
        logic [3:0] dataBits;
        ua_stop_t stop;
    } ua_fmt_t;

    // host register port request
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ua_req_t;

    // one assembled receive character
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parityErr;
        logic framingErr;
        logic breakErr;
    } ua_rxchar_t;

endpackage

// file: src/ua_fifo_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ua_defines.svh"

module ua_fifo_irq_ctrl
    import ua_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host register port
    input wire ua_pkg::ua_req_t req,
    output logic [7:0] rdData,
    output logic irq,
    output logic txSlotAvail_n,
    output logic rxDataAvail_n,
    // receive shift register side
    input wire ua_pkg::ua_rxchar_t rxChar,
    input wire logic baudTick16,
    input wire logic modemChange,
    // transmit shift register side
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady,
    input wire logic txShiftBusy,
    output ua_pkg::ua_fmt_t fmt
);
    import ua_pkg::*;

    typedef struct packed {
        logic [3:0] interrupt_enable;
        logic fifoEn;
        logic mode1;
        logic [1:0] trig;
        logic [7:0] line_control;
        ua_fmt_t fmt;
        logic [15:0][7:0] rxMem;
        logic [3:0] rxRd;
        logic [3:0] rxWr;
        logic [4:0] rxCnt;
        logic [15:0][7:0] txMem;
        logic [3:0] txRd;
        logic [3:0] txWr;
        logic [4:0] txCnt;
        logic [1:0][7:0] txBuf;
        logic [1:0] bufV;
        logic [3:0] lsErr;
        logic fifoErr;
        logic lsPend;
        logic toPend;
        logic threPend;
        logic msPend;
        logic [9:0] toTimer;
        logic rxAvailN;
        logic txSlotN;
        logic [7:0] rdData;
        logic irq;
    } ua_state_t;

    ua_state_t s;
    ua_state_t next_s;

    logic [4:0] cap;
    logic [4:0] trigN;
    logic rdaLevel;
    logic lsAct;
    logic rdaAct;
    logic toAct;
    logic threAct;
    logic msAct;
    logic [3:0] isrId;
    logic [7:0] isrVal;
    logic [7:0] lsrVal;
    logic [9:0] toLimit;
    logic rdStb;
    logic wrStb;

    always_comb
    begin
        case (s.trig)
            2'h0: trigN = 5'h01;
            2'h1: trigN = 5'h04;
            2'h2: trigN = 5'h08;
            default: trigN = 5'h0E;
        endcase
    end

    assign rdStb = req.cs & req.rd;
    assign wrStb = req.cs & req.wr;
    // without fifos each side holds a single character
    assign cap = s.fifoEn ? `UA_DEPTH : 5'h01;
    assign rdaLevel = s.fifoEn ? (s.rxCnt >= trigN) : (s.rxCnt != 5'h00);
    // with all enables clear no source is active: polled mode
    assign lsAct = s.interrupt_enable[2] & s.lsPend;
    assign rdaAct = s.interrupt_enable[0] & rdaLevel;
    assign toAct = s.interrupt_enable[0] & s.toPend;
    assign threAct = s.interrupt_enable[1] & s.threPend;
    assign msAct = s.interrupt_enable[3] & s.msPend;
    // approximate frame: start, data, parity or stop, stop
    assign toLimit = 10'(`UA_TO_CHARS * `UA_TICKS_PER_BIT * (32'(s.fmt.dataBits) + 3));

    always_comb
    begin
        if (lsAct)
            isrId = `UA_ID_LS;
        else if (rdaAct)
            isrId = `UA_ID_RDA;
        else if (toAct)
            isrId = `UA_ID_TO;
        else if (threAct)
            isrId = `UA_ID_THRE;
        else if (msAct)
            isrId = `UA_ID_MS;
        else
            isrId = `UA_ID_NONE;
    end

    assign isrVal = {s.fifoEn, s.fifoEn, 2'h0, isrId};
    assign lsrVal = {s.fifoErr, (s.txCnt == 5'h00) & ~(|s.bufV) & ~txShiftBusy,
        s.txCnt == 5'h00, s.lsErr, s.rxCnt != 5'h00};

    always_comb
    begin
        logic rxPop;
        logic txPush;
        logic rxPush;
        logic bufPop;
        logic bufPush;
        logic rxClr;
        logic txClr;
        logic isrRd;
        rxPop = 1'b0;
        txPush = 1'b0;
        rxPush = 1'b0;
        bufPop = 1'b0;
        bufPush = 1'b0;
        rxClr = 1'b0;
        txClr = 1'b0;
        isrRd = 1'b0;
        next_s = s;

        // register reads; value captured with the strobe
        if (rdStb)
        begin
            case (req.addr)
                `UA_OFF_DATA:
                begin
                    next_s.rdData = s.rxMem[s.rxRd];
                    rxPop = s.rxCnt != 5'h00;
                end
                `UA_OFF_IER: next_s.rdData = {4'h0, s.interrupt_enable};
                `UA_OFF_FCR_ISR:
                begin
                    next_s.rdData = isrVal;
                    isrRd = 1'b1;
                end
                `UA_OFF_LCR: next_s.rdData = s.line_control;
                `UA_OFF_LSR:
                begin
                    next_s.rdData = lsrVal;
                    next_s.lsErr = 4'h0;
                    next_s.fifoErr = 1'b0;
                    next_s.lsPend = 1'b0;
                end
                default: next_s.rdData = 8'h00;
            endcase
        end

        if (isrRd)
        begin
            case (isrId)
                `UA_ID_LS: next_s.lsPend = 1'b0;
                `UA_ID_TO: next_s.toPend = 1'b0;
                `UA_ID_THRE: next_s.threPend = 1'b0;
                `UA_ID_MS: next_s.msPend = 1'b0;
                default: next_s.msPend = s.msPend;
            endcase
        end

        if (wrStb)
        begin
            case (req.addr)
                `UA_OFF_DATA:
                begin
                    txPush = s.txCnt < cap;
                    next_s.threPend = 1'b0;
                end
                `UA_OFF_IER:
                begin
                    next_s.interrupt_enable = req.wdata[3:0];
                    // enabling with an empty holder raises it at once
                    if (req.wdata[1] & ~s.interrupt_enable[1] & (s.txCnt == 5'h00))
                        next_s.threPend = 1'b1;
                end
                `UA_OFF_FCR_ISR:
                begin
                    // other fields only with enable written as one
                    if (req.wdata[`UA_FCR_EN])
                    begin
                        next_s.fifoEn = 1'b1;
                        next_s.mode1 = req.wdata[`UA_FCR_MODE];
                        next_s.trig = req.wdata[7:6];
                        rxClr = req.wdata[`UA_FCR_RXCLR] | ~s.fifoEn;
                        txClr = req.wdata[`UA_FCR_TXCLR] | ~s.fifoEn;
                    end
                    else
                    begin
                        next_s.fifoEn = 1'b0;
                        // disable write always empties both sides
                        rxClr = 1'b1;
                        txClr = 1'b1;
                    end
                end
                `UA_OFF_LCR:
                begin
                    next_s.line_control = req.wdata;
                    next_s.fmt.dataBits = 4'h5 + {2'h0, req.wdata[1:0]};
                    if (!req.wdata[2])
                        next_s.fmt.stop = UA_STOP_ONE;
                    else if (req.wdata[1:0] == 2'h0)
                        next_s.fmt.stop = UA_STOP_ONE_HALF;
                    else
                        next_s.fmt.stop = UA_STOP_TWO;
                end
                default: next_s.line_control = s.line_control;
            endcase
        end

        // fifo keeps filling past trigger until full; a full fifo overruns
        if (rxChar.valid)
        begin
            rxPush = s.rxCnt < cap;
            // status posted as the character moves in; set beats clear
            next_s.lsErr = next_s.lsErr | {rxChar.breakErr, rxChar.framingErr,
                rxChar.parityErr, ~rxPush};
            if (rxChar.breakErr | rxChar.framingErr | rxChar.parityErr | ~rxPush)
                next_s.lsPend = 1'b1;
            if ((rxChar.breakErr | rxChar.framingErr | rxChar.parityErr) & s.fifoEn)
                next_s.fifoErr = 1'b1;
        end

        if (modemChange)
            next_s.msPend = 1'b1;

        if (rxClr)
        begin
            next_s.rxRd = 4'h0;
            next_s.rxWr = 4'h0;
            next_s.rxCnt = 5'h00;
            next_s.toPend = 1'b0;
        end
        else
        begin
            if (rxPush)
            begin
                next_s.rxMem[s.rxWr] = rxChar.data;
                next_s.rxWr = s.rxWr + 4'h1;
            end
            if (rxPop)
                next_s.rxRd = s.rxRd + 4'h1;
            next_s.rxCnt = s.rxCnt + {4'h0, rxPush} - {4'h0, rxPop};
        end

        // two entry buffer toward the shift register
        bufPop = s.bufV[0] & txReady;
        bufPush = (s.txCnt != 5'h00) & ~s.bufV[1] & ~txClr;
        if (bufPop)
        begin
            next_s.txBuf[0] = s.txBuf[1];
            next_s.bufV = {1'b0, s.bufV[1]};
        end
        if (bufPush)
        begin
            if (!next_s.bufV[0])
            begin
                next_s.txBuf[0] = s.txMem[s.txRd];
                next_s.bufV[0] = 1'b1;
            end
            else
            begin
                next_s.txBuf[1] = s.txMem[s.txRd];
                next_s.bufV[1] = 1'b1;
            end
        end

        // transmit fifo pointers; shift side untouched
        if (txClr)
        begin
            next_s.txRd = 4'h0;
            next_s.txWr = 4'h0;
            next_s.txCnt = 5'h00;
            next_s.threPend = 1'b1;
        end
        else
        begin
            if (txPush)
            begin
                next_s.txMem[s.txWr] = req.wdata;
                next_s.txWr = s.txWr + 4'h1;
            end
            if (bufPush)
                next_s.txRd = s.txRd + 4'h1;
            next_s.txCnt = s.txCnt + {4'h0, txPush} - {4'h0, bufPush};
            if (bufPush & ~txPush & (s.txCnt == 5'h01))
                next_s.threPend = 1'b1;
        end

        // idle timer, restarted by arrival or read
        if (rxPush | rxPop | ~s.fifoEn | (s.rxCnt == 5'h00) | rdaLevel)
            next_s.toTimer = 10'h000;
        else if (baudTick16 & ~s.toPend)
        begin
            if (s.toTimer >= toLimit - 10'h001)
            begin
                next_s.toTimer = 10'h000;
                next_s.toPend = 1'b1;
            end
            else
                next_s.toTimer = s.toTimer + 10'h001;
        end
        if (rxPop & ~rxPush)
            next_s.toPend = 1'b0;

        if (next_s.fifoEn & next_s.mode1)
            next_s.txSlotN = next_s.txCnt == `UA_DEPTH;
        else
            next_s.txSlotN = next_s.txCnt != 5'h00;

        if (next_s.fifoEn & next_s.mode1)
        begin
            if (next_s.rxCnt == 5'h00)
                next_s.rxAvailN = 1'b1;
            else if ((s.rxCnt >= trigN) | s.toPend)
                next_s.rxAvailN = 1'b0;
        end
        else
            next_s.rxAvailN = next_s.rxCnt == 5'h00;

        next_s.irq = isrId != `UA_ID_NONE;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.interrupt_enable <= `UA_IER_RST;
            s.trig <= `UA_TRIG_RST;
            s.line_control <= `UA_LCR_RST;
            s.fmt.dataBits <= 4'h5;
            s.fmt.stop <= UA_STOP_ONE;
            s.threPend <= 1'b1;
            s.rxAvailN <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign rdData = s.rdData;
    assign irq = s.irq;
    assign txSlotAvail_n = s.txSlotN;
    assign rxDataAvail_n = s.rxAvailN;
    assign txValid = s.bufV[0];
    assign txData = s.txBuf[0];
    assign fmt = s.fmt;

    property p_isr_ls;
        @(posedge clk) disable iff (rst)
        (rdStb && req.addr == `UA_OFF_FCR_ISR && lsAct) |=> (rdData[5:0] == 6'h06);
    endproperty
    a_isr_ls: assert property (p_isr_ls) else $error("line status id wrong");

    property p_isr_idle;
        @(posedge clk) disable iff (rst)
        (rdStb && req.addr == `UA_OFF_FCR_ISR && !irq && isrId == `UA_ID_NONE)
            |=> rdData[0] && !$past(irq);
    endproperty
    a_isr_idle: assert property (p_isr_idle) else $error("idle status bit wrong");

    property p_isr_fifo;
        @(posedge clk) disable iff (rst)
        (rdStb && req.addr == `UA_OFF_FCR_ISR) |=> (rdData[7:6] == {2{$past(s.fifoEn)}});
    endproperty
    a_isr_fifo: assert property (p_isr_fifo) else $error("fifo flags in status wrong");

    property p_rda_irq;
        @(posedge clk) disable iff (rst)
        (s.fifoEn && s.interrupt_enable[0] && s.rxCnt >= trigN) |=> irq;
    endproperty
    a_rda_irq: assert property (p_rda_irq) else $error("rx ready irq missing");

    property p_tx_m1;
        @(posedge clk) disable iff (rst)
        (s.fifoEn && s.mode1) |-> (txSlotAvail_n == (s.txCnt == `UA_DEPTH));
    endproperty
    a_tx_m1: assert property (p_tx_m1) else $error("mode 1 tx ready wrong");

    property p_rx_m0;
        @(posedge clk) disable iff (rst)
        !(s.fifoEn && s.mode1) |-> (rxDataAvail_n == (s.rxCnt == 5'h00));
    endproperty
    a_rx_m0: assert property (p_rx_m0) else $error("mode 0 rx ready wrong");

    property p_fcr_off;
        @(posedge clk) disable iff (rst)
        (wrStb && req.addr == `UA_OFF_FCR_ISR && !req.wdata[0]) |=> !s.fifoEn && s.rxCnt == 0;
    endproperty
    a_fcr_off: assert property (p_fcr_off) else $error("fifo disable ignored");

    property p_rx_clr;
        @(posedge clk) disable iff (rst)
        (wrStb && req.addr == `UA_OFF_FCR_ISR && req.wdata[1:0] == 2'h3) |=> s.rxCnt == 0;
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx fifo not cleared");

    property p_lcr_fmt;
        @(posedge clk) disable iff (rst)
        (wrStb && req.addr == `UA_OFF_LCR && req.wdata[2:0] == 3'h4)
            |=> fmt.dataBits == 4'h5 && fmt.stop == UA_STOP_ONE_HALF;
    endproperty
    a_lcr_fmt: assert property (p_lcr_fmt) else $error("format decode wrong");

    property p_lsr_dr;
        @(posedge clk) disable iff (rst)
        (rdStb && req.addr == `UA_OFF_LSR) |=> rdData[0] == ($past(s.rxCnt) != 5'h00);
    endproperty
    a_lsr_dr: assert property (p_lsr_dr) else $error("data ready bit wrong");

    c_timeout: cover property (@(posedge clk) disable iff (rst) $rose(s.toPend));
    c_tx_full: cover property (@(posedge clk) disable iff (rst) s.txCnt == `UA_DEPTH);
    c_m1_rx: cover property (@(posedge clk) disable iff (rst) s.mode1 && $fell(rxDataAvail_n));

endmodule // ua_fifo_irq_ctrl

`default_nettype wire
